// ==== hw/dcbr_pkg.sv ====
// Package of constants, pin bundle and a helper function for the dual counter block.
package dcbr_pkg;

  // ----------------------------------------------------------------
  // Widths and fixed values
  // ----------------------------------------------------------------
  localparam int DCBR_CNT_W = 16;
  localparam int DCBR_BYTE_W = 8;
  localparam int DCBR_SYNC_DEPTH = 3;
  // Idle pin levels in bundle order: clocks low, second enable low, all four selects high.
  localparam logic [7:0] DCBR_PIN_IDLE = 8'h0f;

  // ----------------------------------------------------------------
  // Byte select codes, order {second_high, second_low, first_high, first_low}
  // ----------------------------------------------------------------
  localparam logic [3:0] DCBR_SEL_NONE = 4'hf;
  localparam logic [3:0] DCBR_SEL_A_LO = 4'he;
  localparam logic [3:0] DCBR_SEL_A_HI = 4'hd;
  localparam logic [3:0] DCBR_SEL_B_LO = 4'hb;
  localparam logic [3:0] DCBR_SEL_B_HI = 4'h7;

  // ----------------------------------------------------------------
  // APB register map, byte addresses
  // ----------------------------------------------------------------
  localparam int DCBR_ADDR_W = 8;
  localparam logic [7:0] DCBR_OFS_CTRL = 8'h00;
  localparam logic [7:0] DCBR_OFS_LIVE = 8'h04;
  localparam logic [7:0] DCBR_OFS_HOLD = 8'h08;
  localparam int DCBR_CTRL_SNAP_BIT = 0;

  // ----------------------------------------------------------------
  // Pin bundle that passes the input synchroniser together
  // ----------------------------------------------------------------
  typedef struct packed {
    logic clk_a;
    logic clk_b;
    logic snap;
    logic en_b_n;
    logic [3:0] sel_n;
  } dcbr_pins_s;

  // Picks the held byte addressed by a one-low select code, zero otherwise.
  function automatic logic [7:0] dcbr_byte_pick(input logic [31:0] hold, input logic [3:0] sel_n);
    logic [7:0] b;
    b = 8'h00;
    unique case (sel_n)
      DCBR_SEL_A_LO: b = hold[7:0];
      DCBR_SEL_A_HI: b = hold[15:8];
      DCBR_SEL_B_LO: b = hold[23:16];
      DCBR_SEL_B_HI: b = hold[31:24];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

endpackage

// ==== hw/dcbr_top.sv ====
// Dual 16-bit counters with snapshot register, byte readout and APB window.
`timescale 1ns/1ns
module dcbr_top
  import dcbr_pkg::*;
#(
  parameter int CNT_W = DCBR_CNT_W
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic FIRST_COUNT_CLOCK,
  input wire logic SECOND_COUNT_CLOCK,
  input wire logic SNAPSHOT_CLOCK,
  input wire logic COUNTERS_CLEAR_N,
  input wire logic SECOND_COUNT_ENABLE_N,
  input wire logic FIRST_LOW_BYTE_SEL_N,
  input wire logic FIRST_HIGH_BYTE_SEL_N,
  input wire logic SECOND_LOW_BYTE_SEL_N,
  input wire logic SECOND_HIGH_BYTE_SEL_N,
  output logic FIRST_TERMINAL_COUNT_N,
  output logic [7:0] BYTE_OUT_BUS,
  output logic BYTE_OUT_BUS_OE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);

  // ----------------------------------------------------------------
  // Input synchroniser and filter
  // ----------------------------------------------------------------
  dcbr_pins_s pins_raw;
  dcbr_pins_s sync1_reg, sync2_reg, sync3_reg, filt_reg;
  wire logic [7:0] agree;
  wire dcbr_pins_s filt_next;
  wire logic rise_a, rise_b, rise_snap;

  assign pins_raw = '{clk_a: FIRST_COUNT_CLOCK, clk_b: SECOND_COUNT_CLOCK,
                      snap: SNAPSHOT_CLOCK, en_b_n: SECOND_COUNT_ENABLE_N,
                      sel_n: {SECOND_HIGH_BYTE_SEL_N, SECOND_LOW_BYTE_SEL_N,
                              FIRST_HIGH_BYTE_SEL_N, FIRST_LOW_BYTE_SEL_N}};

  // A pin only counts as changed once the second and third stages agree.
  assign agree = ~(sync2_reg ^ sync3_reg);
  assign filt_next = (agree & sync3_reg) | (~agree & filt_reg);
  assign rise_a = filt_next.clk_a & ~filt_reg.clk_a;
  assign rise_b = filt_next.clk_b & ~filt_reg.clk_b;
  assign rise_snap = filt_next.snap & ~filt_reg.snap;

  // Three stages; the first is read only by the second.
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      sync1_reg <= DCBR_PIN_IDLE;
      sync2_reg <= DCBR_PIN_IDLE;
      sync3_reg <= DCBR_PIN_IDLE;
      filt_reg <= DCBR_PIN_IDLE;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= filt_next;
    end
  end

  // ----------------------------------------------------------------
  // Counters and terminal count
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt_a_reg, cnt_b_reg;
  logic tc_n_reg;
  wire logic [CNT_W-1:0] cnt_a_next, cnt_b_next;
  wire logic cnt_b_go;

  assign cnt_a_next = rise_a ? cnt_a_reg + 1'b1 : cnt_a_reg;
  assign cnt_b_go = rise_b & ~filt_next.en_b_n;
  assign cnt_b_next = cnt_b_go ? cnt_b_reg + 1'b1 : cnt_b_reg;

  // Clear acts asynchronously; its release is not synchronised, so a count edge
  // right at the release may or may not be counted.
  always_ff @(posedge SYS_CLK or posedge RESET or negedge COUNTERS_CLEAR_N) begin
    if (RESET || !COUNTERS_CLEAR_N) begin
      cnt_a_reg <= '0;
      cnt_b_reg <= '0;
      tc_n_reg <= 1'b1;
    end else begin
      cnt_a_reg <= cnt_a_next;
      cnt_b_reg <= cnt_b_next;
      tc_n_reg <= ~(&cnt_a_next);
    end
  end

  assign FIRST_TERMINAL_COUNT_N = tc_n_reg;

  // ----------------------------------------------------------------
  // Holding register and byte bus
  // ----------------------------------------------------------------
  logic [2*CNT_W-1:0] hold_reg;
  logic [7:0] bus_reg;
  logic oe_reg;
  logic soft_snap_reg;
  wire logic take_snap;
  wire logic [DCBR_CNT_W-1:0] held_a, held_b;
  wire logic [31:0] hold_word;

  // Each held count fills its own 16-bit half, so a narrow build keeps the word layout.
  assign take_snap = rise_snap | soft_snap_reg;
  assign held_a = DCBR_CNT_W'(hold_reg[CNT_W-1:0]);
  assign held_b = DCBR_CNT_W'(hold_reg[2*CNT_W-1:CNT_W]);
  assign hold_word = {held_b, held_a};

  // The output byte is registered, so it follows the filtered selects one cycle later.
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      hold_reg <= '0;
      bus_reg <= 8'h00;
      oe_reg <= 1'b0;
    end else begin
      if (take_snap) begin
        hold_reg <= {cnt_b_reg, cnt_a_reg};
      end
      bus_reg <= dcbr_byte_pick(hold_word, filt_next.sel_n);
      oe_reg <= (filt_next.sel_n != DCBR_SEL_NONE);
    end
  end

  assign BYTE_OUT_BUS = bus_reg;
  assign BYTE_OUT_BUS_OE = oe_reg;

  // ----------------------------------------------------------------
  // APB slave: zero wait states, error on unmapped offsets
  // ----------------------------------------------------------------
  logic [31:0] prdata_reg;
  logic err_reg;
  wire logic setup_ph, wr_ctrl, mapped;
  wire logic [31:0] rd_mux;
  wire logic [31:0] live_word;

  // Live counts use the same half-word layout as the holding register.
  assign live_word = {DCBR_CNT_W'(cnt_b_reg), DCBR_CNT_W'(cnt_a_reg)};

  assign setup_ph = PSEL & ~PENABLE;
  assign mapped = (PADDR == DCBR_OFS_CTRL) | (PADDR == DCBR_OFS_LIVE) |
                  (PADDR == DCBR_OFS_HOLD);
  assign wr_ctrl = PSEL & PENABLE & PWRITE & (PADDR == DCBR_OFS_CTRL);
  assign rd_mux = (PADDR == DCBR_OFS_LIVE) ? live_word :
                  (PADDR == DCBR_OFS_HOLD) ? hold_word : 32'h0000_0000;

  // Read data is latched in the setup phase and presented in the access phase.
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      prdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
      soft_snap_reg <= 1'b0;
    end else begin
      if (setup_ph) begin
        prdata_reg <= PWRITE ? 32'h0000_0000 : rd_mux;
        err_reg <= ~mapped;
      end
      soft_snap_reg <= wr_ctrl & PWDATA[DCBR_CTRL_SNAP_BIT];
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & err_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  property p_count_a;
    (rise_a && COUNTERS_CLEAR_N) ##1 COUNTERS_CLEAR_N |-> cnt_a_reg == $past(cnt_a_reg) + 1'b1;
  endproperty
  a_count_a: assert property (p_count_a) else $error("first counter missed an edge");

  property p_count_b;
    (rise_b && !filt_next.en_b_n && COUNTERS_CLEAR_N) ##1 COUNTERS_CLEAR_N
      |-> cnt_b_reg == $past(cnt_b_reg) + 1'b1;
  endproperty
  a_count_b: assert property (p_count_b) else $error("second counter missed an edge");

  property p_hold_b;
    (!rise_b || filt_next.en_b_n) ##1 COUNTERS_CLEAR_N |-> $stable(cnt_b_reg);
  endproperty
  a_hold_b: assert property (p_hold_b) else $error("second counter moved while disabled");

  property p_tc;
    FIRST_TERMINAL_COUNT_N == !(&cnt_a_reg);
  endproperty
  a_tc: assert property (p_tc) else $error("terminal count disagrees with count");

  property p_clear;
    !COUNTERS_CLEAR_N |-> cnt_a_reg == '0 && cnt_b_reg == '0 && FIRST_TERMINAL_COUNT_N;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero counters");

  property p_snap;
    take_snap |=> hold_reg == {$past(cnt_b_reg), $past(cnt_a_reg)};
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot captured wrong value");

  property p_hold_stable;
    !take_snap |=> $stable(hold_reg);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("holding register drifted");

  property p_sel_a;
    (filt_next.sel_n == DCBR_SEL_A_LO || filt_next.sel_n == DCBR_SEL_A_HI)
      |=> BYTE_OUT_BUS_OE && BYTE_OUT_BUS ==
          ($past(filt_next.sel_n) == DCBR_SEL_A_LO ? $past(held_a[7:0]) : $past(held_a[15:8]));
  endproperty
  a_sel_a: assert property (p_sel_a) else $error("wrong first counter byte on bus");

  property p_sel_b;
    (filt_next.sel_n == DCBR_SEL_B_LO || filt_next.sel_n == DCBR_SEL_B_HI)
      |=> BYTE_OUT_BUS_OE && BYTE_OUT_BUS ==
          ($past(filt_next.sel_n) == DCBR_SEL_B_LO ? $past(held_b[7:0]) : $past(held_b[15:8]));
  endproperty
  a_sel_b: assert property (p_sel_b) else $error("wrong second counter byte on bus");

  property p_idle;
    (filt_next.sel_n == DCBR_SEL_NONE) |=> !BYTE_OUT_BUS_OE;
  endproperty
  a_idle: assert property (p_idle) else $error("bus driven with no select");

  c_wrap_a: cover property (rise_a && &cnt_a_reg ##1 cnt_a_reg == '0);
  c_chain: cover property (cnt_b_go && !FIRST_TERMINAL_COUNT_N);
  c_read_b_hi: cover property (take_snap ##[1:50] filt_next.sel_n == DCBR_SEL_B_HI);
  c_clear: cover property (!COUNTERS_CLEAR_N && cnt_a_reg == '0);

endmodule // dcbr_top

// ==== testbench/dcbr_host_bus_model.sv ====
// Host data bus model that resolves the three-state byte bus of the counter block.
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Bus resolution
// ----------------------------------------------------------------
module dcbr_host_bus_model (
  input wire logic clk,
  input wire logic [7:0] byte_drv,
  input wire logic byte_oe,
  output logic [7:0] byte_seen
);
  logic [7:0] last_reg = 8'h00;
  // A released bus shows the inverse of the last byte, so a stale value never reads as good.
  assign byte_seen = byte_oe ? byte_drv : ~last_reg;
  // Remember the byte that the device drove last.
  always_ff @(posedge clk) begin
    if (byte_oe) begin
      last_reg <= byte_drv;
    end
  end
endmodule // dcbr_host_bus_model

// ==== testbench/tb_dual_counter_byte_readout.sv ====
// Self-checking bench for the dual counter block with byte readout.
`timescale 1ns/1ns
module tb_dual_counter_byte_readout
  import dcbr_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  // Narrow counters keep the full-count case short; expected values follow this width.
  localparam int CW = 4;
  localparam logic [31:0] FULL = 32'h0000_000f;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clr_n = 1'b1;
  logic en_n = 1'b0;
  logic chain = 1'b0;
  logic [2:0] pins = 3'b000;
  logic [3:0] sel = DCBR_SEL_NONE;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic err;
  logic tc_n, oe, pready, pslverr, en_pin;
  logic [7:0] bout, seen;
  logic [31:0] prdata;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Chained mode wires the terminal count back to the second enable.
  assign en_pin = chain ? tc_n : en_n;
  initial forever #5 clk = ~clk;
  dcbr_top #(.CNT_W(CW)) i_dut (.SYS_CLK(clk), .RESET(rst), .FIRST_COUNT_CLOCK(pins[0]),
    .SECOND_COUNT_CLOCK(pins[1]), .SNAPSHOT_CLOCK(pins[2]), .COUNTERS_CLEAR_N(clr_n),
    .SECOND_COUNT_ENABLE_N(en_pin), .FIRST_LOW_BYTE_SEL_N(sel[0]),
    .FIRST_HIGH_BYTE_SEL_N(sel[1]), .SECOND_LOW_BYTE_SEL_N(sel[2]),
    .SECOND_HIGH_BYTE_SEL_N(sel[3]), .FIRST_TERMINAL_COUNT_N(tc_n), .BYTE_OUT_BUS(bout),
    .BYTE_OUT_BUS_OE(oe), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  dcbr_host_bus_model i_host (.clk(clk), .byte_drv(bout), .byte_oe(oe), .byte_seen(seen));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the edge that sees pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Pulses are kept 40 ns high and low so the input filter never drops one.
  task automatic pulse(input logic [2:0] m, input int n);
    repeat (n) begin
      pins <= m;
      repeat (4) @(posedge clk);
      pins <= 3'b000;
      repeat (4) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic rdbyte(input logic [3:0] code, input logic [7:0] exp);
    sel <= code;
    repeat (6) @(posedge clk);
    chk({31'h0, oe}, 32'h1);
    chk({24'h0, seen}, {24'h0, exp});
    sel <= DCBR_SEL_NONE;
    repeat (21) @(posedge clk);
    chk({31'h0, oe}, 32'h0);
  endtask
  // ----------------------------------------------------------------
  // Timeout and main sequence
  // ----------------------------------------------------------------
  // A hang is cut short well past the roughly 530 cycles the sequence needs.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    pulse(3'b011, 5);
    pulse(3'b100, 1);
    apb(1'b0, DCBR_OFS_HOLD, 32'h0);
    chk(rd, 32'h0005_0005);
    rdbyte(DCBR_SEL_A_LO, 8'h05);
    rdbyte(DCBR_SEL_A_HI, 8'h00);
    rdbyte(DCBR_SEL_B_LO, 8'h05);
    rdbyte(DCBR_SEL_B_HI, 8'h00);
    en_n <= 1'b1;
    pulse(3'b011, 3);
    apb(1'b0, DCBR_OFS_LIVE, 32'h0);
    chk(rd, 32'h0005_0008);
    apb(1'b0, DCBR_OFS_HOLD, 32'h0);
    chk(rd, 32'h0005_0005);
    apb(1'b1, DCBR_OFS_CTRL, 32'h1);
    apb(1'b0, DCBR_OFS_HOLD, 32'h0);
    chk(rd, 32'h0005_0008);
    rdbyte(DCBR_SEL_A_LO, 8'h08);
    apb(1'b0, 8'h0c, 32'h0);
    chk({31'h0, err}, 32'h1);
    clr_n <= 1'b0;
    repeat (3) @(posedge clk);
    apb(1'b0, DCBR_OFS_LIVE, 32'h0);
    chk(rd, 32'h0);
    clr_n <= 1'b1;
    chain <= 1'b1;
    pulse(3'b011, 15);
    chk({31'h0, tc_n}, 32'h0);
    apb(1'b0, DCBR_OFS_LIVE, 32'h0);
    chk(rd, FULL);
    pulse(3'b011, 1);
    apb(1'b0, DCBR_OFS_LIVE, 32'h0);
    chk(rd, 32'h0001_0000);
    chk({31'h0, tc_n}, 32'h1);
    pulse(3'b011, 15);
    chk({31'h0, tc_n}, 32'h0);
    clr_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, tc_n}, 32'h1);
    apb(1'b0, DCBR_OFS_LIVE, 32'h0);
    chk(rd, 32'h0);
    clr_n <= 1'b1;
    final_report();
  end
endmodule // tb_dual_counter_byte_readout
